// ==== hw/flash_program_erase_timing.sv ====
// Purpose: sequences word programs, page erases, partial steps, full erase
// Assumes: requests come from logic on the same clock
// Notes:   requests arriving while busy are refused; at idle the top-priority request is refused in the wrong mode and the rest are dropped
`timescale 1ns/1ns
module flash_program_erase_timing
  import flash_seq_pkg::*;
#(
  parameter int WRITE_CYCLES         = WRITE_CYC,
  parameter int ERASE_PAGE_CYCLES    = ERASE_PAGE_CYC,
  parameter int ERASE_ALL_CYCLES     = ERASE_ALL_CYC,
  parameter int PARTIAL_SETUP_CYCLES = PARTIAL_SETUP_CYC,
  parameter int PARTIAL_ERASE_CYCLES = PARTIAL_ERASE_CYC
) (
  // clock and reset
  input  wire logic                           clock,
  input  wire logic                           nrst,
  // access mode
  input  wire logic [1:0]                     access_mode,
  // requests
  input  wire logic                           write_req,
  input  wire logic [flash_seq_pkg::ADDR_W-1:0] write_addr,
  input  wire logic [flash_seq_pkg::DATA_W-1:0] write_data,
  input  wire logic                           page_erase_req,
  input  wire logic                           partial_page_erase_step,
  input  wire logic [flash_seq_pkg::ADDR_W-1:0] page_addr,
  input  wire logic                           whole_array_erase_cmd,
  // status
  output logic                                ready,
  output logic                                op_done,
  output logic                                cmd_refused,
  output logic                                cache_invalidate,
  // flash array controls
  output logic [flash_seq_pkg::ADDR_W-1:0]    flash_addr,
  output logic [flash_seq_pkg::DATA_W-1:0]    flash_wdata,
  output logic                                flash_prog,
  output logic                                flash_erase_page,
  output logic                                flash_erase_all,
  output logic                                flash_setup,
  output logic                                flash_erase_partial
);
  import flash_seq_pkg::*;

  // expiry is registered in the timer and again in state, so two cycles lag
  localparam int TIMER_LAG = 2;

  typedef struct packed {
    seq_state_t        state;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              done;
    logic              refused;
    logic              cinv;
    logic [CNT_W-1:0]  busy_len;
  } seq_t;

  seq_t             cur;
  seq_t             next_cur;
  logic             timer_load;
  logic [CNT_W-1:0] timer_value;
  logic             timer_expired;
  logic             any_req;

  op_timer #(
    .CNT_W(CNT_W)
  ) i_op_timer (
    .clock     (clock),
    .nrst      (nrst),
    .load      (timer_load),
    .load_value(timer_value),
    .expired   (timer_expired)
  );

  assign any_req = write_req | page_erase_req | partial_page_erase_step
                   | whole_array_erase_cmd;

  always_comb begin
    next_cur         = cur;
    next_cur.done    = 1'b0;
    next_cur.refused = 1'b0;
    timer_load       = 1'b0;
    timer_value      = '0;
    // cache stays invalid for as long as write or erase is open
    next_cur.cinv = (access_mode == MODE_WRITE)
                    || (access_mode == MODE_ERASE);
    if (cur.state == st_idle) begin
      next_cur.busy_len = '0;
    end else begin
      next_cur.busy_len = cur.busy_len + 1'b1;
    end
    case (cur.state)
      st_idle: begin
        // only one operation may start; erase-all has top priority
        if (whole_array_erase_cmd) begin
          if (access_mode == MODE_ERASE) begin
            next_cur.state = st_erase_all;
            timer_load     = 1'b1;
            timer_value    = CNT_W'(ERASE_ALL_CYCLES - TIMER_LAG);
          end else begin
            next_cur.refused = 1'b1;
          end
        end else if (page_erase_req) begin
          if (access_mode == MODE_ERASE) begin
            next_cur.state = st_erase_page;
            next_cur.addr  = page_addr;
            timer_load     = 1'b1;
            timer_value    = CNT_W'(ERASE_PAGE_CYCLES - TIMER_LAG);
          end else begin
            next_cur.refused = 1'b1;
          end
        end else if (partial_page_erase_step) begin
          if (access_mode == MODE_ERASE) begin
            next_cur.state = st_partial_setup;
            next_cur.addr  = page_addr;
            timer_load     = 1'b1;
            timer_value    = CNT_W'(PARTIAL_SETUP_CYCLES - TIMER_LAG);
          end else begin
            next_cur.refused = 1'b1;
          end
        end else if (write_req) begin
          if (access_mode == MODE_WRITE) begin
            next_cur.state = st_program;
            next_cur.addr  = write_addr;
            next_cur.wdata = write_data;
            timer_load     = 1'b1;
            timer_value    = CNT_W'(WRITE_CYCLES - TIMER_LAG);
          end else begin
            next_cur.refused = 1'b1;
          end
        end
      end
      st_partial_setup: begin
        next_cur.refused = any_req;
        if (timer_expired) begin
          next_cur.state = st_partial_erase;
          timer_load     = 1'b1;
          timer_value    = CNT_W'(PARTIAL_ERASE_CYCLES - TIMER_LAG);
        end
      end
      st_program, st_erase_page, st_erase_all, st_partial_erase: begin
        // a busy sequencer never queues; software must wait for ready
        next_cur.refused = any_req;
        if (timer_expired) begin
          next_cur.state = st_idle;
          next_cur.done  = 1'b1;
        end
      end
      default: begin
        next_cur.state = st_idle;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign ready               = (cur.state == st_idle);
  assign op_done             = cur.done;
  assign cmd_refused         = cur.refused;
  assign cache_invalidate    = cur.cinv;
  assign flash_addr          = cur.addr;
  assign flash_wdata         = cur.wdata;
  assign flash_prog          = (cur.state == st_program);
  assign flash_erase_page    = (cur.state == st_erase_page);
  assign flash_erase_all     = (cur.state == st_erase_all);
  assign flash_setup         = (cur.state == st_partial_setup);
  assign flash_erase_partial = (cur.state == st_partial_erase);

  // checks
  property p_write_time;
    @(posedge clock) disable iff (!nrst)
      flash_prog |-> (cur.busy_len < CNT_W'(WRITE_CYCLES));
  endproperty
  a_write_time: assert property (p_write_time)
    else $error("word program ran past its limit");

  property p_page_time;
    @(posedge clock) disable iff (!nrst)
      flash_erase_page |-> (cur.busy_len < CNT_W'(ERASE_PAGE_CYCLES));
  endproperty
  a_page_time: assert property (p_page_time)
    else $error("page erase ran past its limit");

  property p_all_time;
    @(posedge clock) disable iff (!nrst)
      flash_erase_all |-> (cur.busy_len < CNT_W'(ERASE_ALL_CYCLES));
  endproperty
  a_all_time: assert property (p_all_time)
    else $error("whole-array erase ran past its limit");

  property p_setup_time;
    @(posedge clock) disable iff (!nrst)
      flash_setup |-> (cur.busy_len < CNT_W'(PARTIAL_SETUP_CYCLES));
  endproperty
  a_setup_time: assert property (p_setup_time)
    else $error("partial setup ran past its limit");

  property p_mode_gate;
    @(posedge clock) disable iff (!nrst)
      ($rose(flash_prog) |-> $past(access_mode) == MODE_WRITE)
      and ($rose(flash_erase_page) |-> $past(access_mode) == MODE_ERASE);
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("operation started in the wrong access mode");

  property p_erase_all_mode;
    @(posedge clock) disable iff (!nrst)
      (ready && whole_array_erase_cmd && access_mode != MODE_ERASE)
      |=> !flash_erase_all ##0 cmd_refused;
  endproperty
  a_erase_all_mode: assert property (p_erase_all_mode)
    else $error("whole-array erase not refused outside erase mode");

  property p_cache_inval;
    @(posedge clock) disable iff (!nrst)
      (access_mode == MODE_WRITE || access_mode == MODE_ERASE)
      |=> cache_invalidate;
  endproperty
  a_cache_inval: assert property (p_cache_inval)
    else $error("cache not invalidated in write or erase mode");

  property p_no_overlap;
    @(posedge clock) disable iff (!nrst)
      (!ready && any_req) |=> cmd_refused ##0 ($past(cur.state) != st_idle);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("request during a busy operation was not refused");

  property p_done_ready;
    @(posedge clock) disable iff (!nrst)
      op_done |-> ready && !$past(ready);
  endproperty
  a_done_ready: assert property (p_done_ready)
    else $error("done pulse without return to ready");

endmodule // flash_program_erase_timing

// ==== hw/flash_seq_pkg.sv ====
// Purpose: constants for the flash program and erase sequencer
// Assumes: 125 MHz system clock, times below are worst-case limits
// Notes:   cycle counts round down so each operation stays inside its limit
package flash_seq_pkg;

  localparam int CLOCK_KHZ = 125000;

  // access mode encodings
  localparam logic [1:0] MODE_READ  = 2'h0;
  localparam logic [1:0] MODE_WRITE = 2'h1;
  localparam logic [1:0] MODE_ERASE = 2'h2;

  // limits in their own units
  localparam int T_WRITE_US          = 43;
  localparam int T_ERASE_PAGE_MS     = 87;
  localparam int T_ERASE_ALL_MS      = 173;
  localparam int T_PARTIAL_SETUP_CMS = 108;  // hundredths of a ms
  localparam int T_PARTIAL_ERASE_MS  = 10;

  // cycle counts, rounded down
  localparam int WRITE_CYC         = T_WRITE_US * CLOCK_KHZ / 1000;
  localparam int ERASE_PAGE_CYC    = T_ERASE_PAGE_MS * CLOCK_KHZ;
  localparam int ERASE_ALL_CYC     = T_ERASE_ALL_MS * CLOCK_KHZ;
  localparam int PARTIAL_SETUP_CYC = T_PARTIAL_SETUP_CMS * CLOCK_KHZ / 100;
  localparam int PARTIAL_ERASE_CYC = T_PARTIAL_ERASE_MS * CLOCK_KHZ;

  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 25;

  typedef enum logic [2:0] {
    st_idle,
    st_program,
    st_erase_page,
    st_erase_all,
    st_partial_setup,
    st_partial_erase
  } seq_state_t;

endpackage

// ==== hw/op_timer.sv ====
// Purpose: one-shot down counter that times a flash operation
// Assumes: load_value is two less than the wanted strobe length
// Notes:   expired is a registered one-cycle pulse
`timescale 1ns/1ns
module op_timer #(
  parameter int CNT_W = 25
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  // control
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_value,
  // status
  output logic                  expired
);

  typedef struct packed {
    logic             running;
    logic [CNT_W-1:0] count;
    logic             expired;
  } timer_t;

  timer_t cur;
  timer_t next_cur;

  always_comb begin
    next_cur         = cur;
    next_cur.expired = 1'b0;
    if (load) begin
      next_cur.running = 1'b1;
      next_cur.count   = load_value;
    end else if (cur.running) begin
      if (cur.count == '0) begin
        next_cur.running = 1'b0;
        next_cur.expired = 1'b1;
      end else begin
        next_cur.count = cur.count - 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign expired = cur.expired;

endmodule // op_timer

// ==== bench/flash_program_erase_timing_tb_top.sv ====
// Purpose: self-checking bench for the flash program and erase sequencer
// Assumes: shortened op lengths via parameters, stimulus 1 ns after edge
// Notes:   integer model of op lengths, mode gating and busy refusal
`timescale 1ns/1ns
module flash_program_erase_timing_tb_top;
  import flash_seq_pkg::*;
  // short counts keep the run brief; expectations derive from them
  localparam int NW = 5, NP = 7, NA = 9, NS = 4, NE = 6;
  logic              clock, nrst;
  logic [1:0]        access_mode;
  logic              write_req, page_erase_req;
  logic              partial_page_erase_step, whole_array_erase_cmd;
  logic [ADDR_W-1:0] write_addr, page_addr, flash_addr;
  logic [DATA_W-1:0] write_data, flash_wdata;
  logic              ready, op_done, cmd_refused, cache_invalidate;
  logic              flash_prog, flash_erase_page, flash_erase_all;
  logic              flash_setup, flash_erase_partial;
  int                errors, cmp_count;

  flash_program_erase_timing #(
    .WRITE_CYCLES(NW), .ERASE_PAGE_CYCLES(NP), .ERASE_ALL_CYCLES(NA),
    .PARTIAL_SETUP_CYCLES(NS), .PARTIAL_ERASE_CYCLES(NE)
  ) i_flash_program_erase_timing (
    .clock(clock), .nrst(nrst), .access_mode(access_mode),
    .write_req(write_req), .write_addr(write_addr),
    .write_data(write_data), .page_erase_req(page_erase_req),
    .partial_page_erase_step(partial_page_erase_step),
    .page_addr(page_addr), .whole_array_erase_cmd(whole_array_erase_cmd),
    .ready(ready), .op_done(op_done), .cmd_refused(cmd_refused),
    .cache_invalidate(cache_invalidate), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_prog(flash_prog),
    .flash_erase_page(flash_erase_page), .flash_erase_all(flash_erase_all),
    .flash_setup(flash_setup), .flash_erase_partial(flash_erase_partial)
  );

  always #4 clock = ~clock;

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic strobe(int s);
    case (s)
      0: return flash_prog;
      1: return flash_erase_page;
      2: return flash_setup;
      3: return flash_erase_all;
      default: return flash_erase_partial;
    endcase
  endfunction

  // counts cycles a strobe stands; a poke request is dropped after one edge
  task automatic wait_strobe(int s, bit poke, output int n);
    n = 0;
    while (strobe(s) === 1'b1 && n < 100) begin
      if (n == 1) begin
        write_req = 0;
        check("busy_refused", cmd_refused, poke);
      end
      check("ready_busy", ready, 0);
      n++;
      @(posedge clock);
      #1;
    end
  endtask

  task automatic run(int kind, logic [1:0] mode, bit poke);
    bit                ok;
    int                n;
    int                len [4];
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    len = '{NW, NP, NS, NA};
    ok = (mode == ((kind == 0) ? 2'd1 : 2'd2));
    a = ADDR_W'($urandom);
    d = $urandom;
    access_mode = mode;
    write_addr = a;
    write_data = d;
    page_addr = a;
    write_req = (kind == 0);
    page_erase_req = (kind == 1);
    partial_page_erase_step = (kind == 2);
    whole_array_erase_cmd = (kind == 3);
    @(posedge clock);
    #1;
    write_req = ok && poke;
    page_erase_req = 0;
    partial_page_erase_step = 0;
    whole_array_erase_cmd = 0;
    check("cache_invalidate", cache_invalidate, mode inside {1, 2});
    check("cmd_refused", cmd_refused, !ok);
    check("ready", ready, !ok);
    check("strobe", strobe(kind), ok);
    if (ok) begin
      if (kind != 3) check("flash_addr", flash_addr, a);
      if (kind == 0) check("flash_wdata", flash_wdata, d);
      wait_strobe(kind, poke, n);
      check("op_len", n, len[kind]);
      if (kind == 2) begin
        wait_strobe(4, 0, n);
        check("erase_len", n, NE);
      end
      check("op_done", op_done, 1);
      check("ready_done", ready, 1);
    end else begin
      @(posedge clock);
      #1;
      check("refused_pulse", cmd_refused, 0);
    end
  endtask

  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end

  initial begin
    clock = 0;
    nrst = 0;
    access_mode = 0;
    write_req = 0;
    page_erase_req = 0;
    partial_page_erase_step = 0;
    whole_array_erase_cmd = 0;
    write_addr = 0;
    write_data = 0;
    page_addr = 0;
    void'($urandom(76273));
    repeat (8) @(posedge clock);
    #1;
    check("ready_reset", ready, 1);
    nrst = 1;
    // every mode against every operation, back to back
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        run(k, 2'(m), 0);
      end
    end
    run(0, 2'd1, 1);
    run(2, 2'd2, 1);
    repeat (12) run($urandom % 4, 2'($urandom % 4), 1'($urandom));
    tally_and_finish();
  end
endmodule // flash_program_erase_timing_tb_top
